// File: cso_pkg.sv
// package: register addresses, field positions, reset values and settle timing
package cso_pkg;
    localparam logic [15:0] CSO_ADDR_STANDBY = 16'hffc0;   // standby control register
    localparam logic [15:0] CSO_ADDR_STATUS = 16'hffce;    // cpu clock status register
    localparam logic [15:0] CSO_ADDR_SETTLE = 16'hffcf;    // settle time select register
    localparam logic [7:0] CSO_STANDBY_RESET = 8'h30;      // standby control after reset
    localparam logic [7:0] CSO_SETTLE_RESET = 8'h00;       // settle select after reset
    localparam logic [7:0] CSO_STATUS_RESET = 8'h32;       // status after reset
    localparam logic [7:0] CSO_STATUS_MIRROR = 8'hf4;      // status bits copied from standby
    localparam logic [7:0] CSO_STATUS_ONE = 8'h02;         // status bit that reads 1
    localparam logic [7:0] CSO_SETTLE_MASK = 8'h87;        // writable settle bits
    localparam int CSO_HALT_BIT = 0;                       // halt request
    localparam int CSO_STOP_BIT = 1;                       // stop request
    localparam int CSO_MOSC_BIT = 2;                       // main osc stop
    localparam int CSO_CKHI_BIT = 6;                       // cpu clock select top bit
    localparam int CSO_EXT_CLOCK_SELECT_BIT = 7;                       // external clock select
    localparam int CSO_WAIT_LSB = 0;                       // wait select low bit
    localparam int CSO_WAIT_W = 3;                         // wait select width
    localparam int CSO_CNT_W = 20;                         // settle counter width
    localparam int CSO_LOG_MAX = 19;                       // log2 of longest crystal wait
    localparam logic [CSO_CNT_W-1:0] CSO_EXT_WAIT = 20'h00200; // 512 periods
    typedef enum logic [1:0] {CSO_RUN, CSO_HALT, CSO_STOP, CSO_IDLE} cso_mode_e;
endpackage

// File: cso_wait_if.sv
// interface: settle wait request and done between top and counter
`timescale 1ns/1ps
`default_nettype none
interface cso_wait_if;
    logic start;                    // one-cycle restart pulse
    logic [19:0] limit;             // periods to wait
    logic done;                     // wait complete level
    modport ctl (output start, output limit, input done);
    modport cnt (input start, input limit, output done);
endinterface
`default_nettype wire

// File: cso_settle_counter.sv
// module: oscillation settle wait counter
`timescale 1ns/1ps
`default_nettype none
module cso_settle_counter
    import cso_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    cso_wait_if.cnt w
);
    typedef struct packed {
        logic [CSO_CNT_W-1:0] cnt;  // elapsed periods
        logic busy;                 // counting
        logic done;                 // reached the limit
    } cso_cnt_s;
    cso_cnt_s st_reg, st_next;
    ////////////////////////////////////////////////////////////////////
    // restart from zero on each start, stop once limit reached
    always_comb begin
        st_next = st_reg;
        if (w.start) begin
            st_next.cnt = '0;   // [RULE25]
            st_next.busy = 1'b1;
            st_next.done = 1'b0;
        end else if (st_reg.busy) begin
            if (st_reg.cnt + 20'h00001 >= w.limit) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
            st_next.cnt = st_reg.cnt + 20'h00001;
        end
    end
    // register the state
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign w.done = st_reg.done;
    a_wait_len: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        $rose(st_reg.busy) |-> !st_reg.done) else $error("done while counting"); // [RULE25]
endmodule
`default_nettype wire

// File: cso_clock_status.sv
// module: clock status, settle select and standby mode control
// Summary of operation
// [RULE1] read-only 8-bit cpu clock status register
// [RULE2] status bits 2,4-7 mirror standby control
// [RULE3] status reads 32h after reset
// [RULE4] status at ffce with documented bit layout
// [RULE5] bit0 shows main or subsystem clock
// [RULE6] three-bit field selects cpu clock divider
// [RULE7] main osc status 1 means stopped
// [RULE8] subsystem resistor bit 1 means unused
// [RULE9] settle register resets to 00h
// [RULE10] settle register at ffcf, bits 6-3 zero
// [RULE11] wait 2^19..2^12 periods, or 512 external
// [RULE12] wait applied on stop release
// [RULE13] ext_clock_select picks crystal or external clock
// [RULE14] ext_clock_select set stops on-chip oscillator
// [RULE15] software sets ext_clock_select before stop
// [RULE16] settle register takes bit and byte writes
// [RULE17] software picks 40ms crystal, 4ms ceramic
// [RULE18] halt request bit enters halt
// [RULE19] standby written only by protected write
// [RULE20] software adds three nops after halt
// [RULE21] halt allowed from main or subclock
// [RULE22] request bits encode mode, auto cleared
// [RULE23] halt withholds cpu clock
// [RULE24] only unmasked interrupts release halt
// [RULE25] settle counter restarts, gates clock till done
`timescale 1ns/1ps
`default_nettype none
module cso_clock_status
    import cso_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [15:0] I_ADDR,        // register address
    input wire logic I_WR,                 // byte write strobe
    input wire logic I_BIT_WR,             // single-bit write strobe
    input wire logic [2:0] I_BIT_SEL,      // bit index for bit write
    input wire logic I_PROT_WR,            // protected write, complement check passed
    input wire logic [7:0] I_WDATA,        // write data, bit write uses bit 0
    input wire logic I_RD,                 // read strobe
    input wire logic I_INT_PENDING,        // unmasked interrupt request, same clock
    output logic [7:0] O_RDATA,            // registered read data
    output logic O_CPU_CLK_EN,             // cpu clock enable
    output logic O_MAIN_OSC_EN,            // on-chip main oscillator enable
    output logic O_EXT_CLK_SEL,            // run from external clock on out pin
    output logic O_SUB_CLK_SEL,            // cpu on subsystem clock
    output logic [1:0] O_CPU_DIV_LOG,      // log2 of main clock divider
    output logic O_SUB_OSC_EN              // subsystem oscillator enable
);
    typedef struct packed {
        logic [7:0] standby;        // standby control register
        logic [7:0] settle;         // settle time select register
        logic [7:0] rdata;          // read data
        logic wait_on;              // stop release wait running
        logic cpu_en;
        logic osc_en;
        logic ext_sel;
        logic sub_sel;
        logic [1:0] div_log;
        logic sub_en;
    } cso_top_s;
    cso_top_s st_reg, st_next;
    cso_wait_if w();
    logic start_w;
    logic [CSO_CNT_W-1:0] limit_w;
    ////////////////////////////////////////////////////////////////////
    // compose the status view of the standby register
    function automatic logic [7:0] status_of(input logic [7:0] sb);
        logic [7:0] s;
        s = (sb & CSO_STATUS_MIRROR) | CSO_STATUS_ONE;   // [RULE2] [RULE4] [RULE7] [RULE8]
        s[0] = sb[CSO_CKHI_BIT];                         // [RULE5]
        return s;
    endfunction
    // settle wait length from the select register
    function automatic logic [CSO_CNT_W-1:0] wait_of(input logic [7:0] os);
        logic [4:0] sh;
        sh = 5'(CSO_LOG_MAX) - {2'b00, os[CSO_WAIT_LSB +: CSO_WAIT_W]};
        if (os[CSO_EXT_CLOCK_SELECT_BIT]) begin
            return CSO_EXT_WAIT;                         // [RULE11]
        end
        return CSO_CNT_W'(1) << sh;                      // [RULE11]
    endfunction
    function automatic cso_mode_e mode_of(input logic [7:0] sb);
        return cso_mode_e'({sb[CSO_STOP_BIT], sb[CSO_HALT_BIT]}); // [RULE22]
    endfunction
    ////////////////////////////////////////////////////////////////////
    // next state: register writes, mode sequencing, outputs
    always_comb begin
        cso_mode_e m;
        m = mode_of(st_reg.standby);
        st_next = st_reg;
        start_w = 1'b0;
        limit_w = wait_of(st_reg.settle);                // [RULE12]
        // protected full-byte write is the only way into standby
        if (I_PROT_WR && I_ADDR == CSO_ADDR_STANDBY) begin
            st_next.standby = I_WDATA;                   // [RULE19] [RULE18] [RULE21]
        end else if (m == CSO_HALT || m == CSO_IDLE) begin
            if (I_INT_PENDING) begin
                st_next.standby[CSO_HALT_BIT] = 1'b0;    // [RULE24] [RULE22]
                st_next.standby[CSO_STOP_BIT] = 1'b0;
            end
        end else if (m == CSO_STOP && !st_reg.wait_on && I_INT_PENDING) begin
            start_w = 1'b1;                              // [RULE12] [RULE25]
            st_next.wait_on = 1'b1;
        end
        // wait finished: release stop, clock resumes
        if (st_reg.wait_on && w.done && !start_w) begin
            st_next.wait_on = 1'b0;
            st_next.standby[CSO_STOP_BIT] = 1'b0;        // [RULE22]
        end
        // settle register: byte or single-bit writes, fixed bits stay 0
        if (I_WR && I_ADDR == CSO_ADDR_SETTLE) begin
            st_next.settle = I_WDATA & CSO_SETTLE_MASK;  // [RULE16] [RULE10]
        end else if (I_BIT_WR && I_ADDR == CSO_ADDR_SETTLE) begin
            st_next.settle[I_BIT_SEL] = I_WDATA[0] & CSO_SETTLE_MASK[I_BIT_SEL]; // [RULE16]
        end
        // reads; status is never written, so writes to it are dropped
        if (I_RD) begin
            unique case (I_ADDR)
                CSO_ADDR_STATUS: st_next.rdata = status_of(st_reg.standby); // [RULE1]
                CSO_ADDR_SETTLE: st_next.rdata = st_reg.settle;
                CSO_ADDR_STANDBY: st_next.rdata = st_reg.standby;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // clock outputs; cpu gated in any standby mode or while waiting
        st_next.cpu_en = (mode_of(st_next.standby) == CSO_RUN) && !st_next.wait_on; // [RULE23]
        st_next.ext_sel = st_next.settle[CSO_EXT_CLOCK_SELECT_BIT];                 // [RULE13]
        // main osc off with ext_clock_select, in stop outside the wake wait, or on subclock with main osc stop bit
        st_next.osc_en = !st_next.settle[CSO_EXT_CLOCK_SELECT_BIT]                  // [RULE14]
            && !(st_next.standby[CSO_STOP_BIT] && !st_next.wait_on)
            && !(st_next.standby[CSO_MOSC_BIT] && st_next.standby[CSO_CKHI_BIT]);
        st_next.sub_sel = st_next.standby[CSO_CKHI_BIT];                // [RULE6]
        st_next.div_log = st_next.standby[5:4];                         // [RULE6]
        st_next.sub_en = !st_next.standby[7];                           // [RULE8]
    end
    // register state; standby and settle reset values from the package
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            st_reg <= '0;
            st_reg.standby <= CSO_STANDBY_RESET;         // [RULE3]
            st_reg.settle <= CSO_SETTLE_RESET;           // [RULE9]
            st_reg.rdata <= 8'h00;
            st_reg.cpu_en <= 1'b1;
            st_reg.osc_en <= 1'b1;
            st_reg.sub_en <= 1'b1;
            st_reg.div_log <= 2'b11;
        end else begin
            st_reg <= st_next;
        end
    end
    assign w.start = start_w;
    assign w.limit = limit_w;
    cso_settle_counter u_cnt (
        .I_CLK(I_CLK),
        .I_RESET_N(I_RESET_N),
        .w(w)
    );
    assign O_RDATA = st_reg.rdata;
    assign O_CPU_CLK_EN = st_reg.cpu_en;
    assign O_MAIN_OSC_EN = st_reg.osc_en;
    assign O_EXT_CLK_SEL = st_reg.ext_sel;
    assign O_SUB_CLK_SEL = st_reg.sub_sel;
    assign O_CPU_DIV_LOG = st_reg.div_log;
    assign O_SUB_OSC_EN = st_reg.sub_en;
    ////////////////////////////////////////////////////////////////////
    sequence s_stop_wake;
        mode_of(st_reg.standby) == CSO_STOP && !st_reg.wait_on && I_INT_PENDING
            && !I_PROT_WR;
    endsequence
    a_status_read: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_RD && I_ADDR == CSO_ADDR_STATUS |=> O_RDATA == (($past(st_reg.standby) & 8'hf4)
        | 8'h02 | {7'h00, $past(st_reg.standby[6])})) else $error("status read wrong"); // [RULE2]
    a_status_fixed: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        $past(I_RD) && $past(I_ADDR) == 16'hffce |-> O_RDATA[3:1] ==? 3'b0?1)
        else $error("status fixed bits"); // [RULE4]
    a_settle_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        st_reg.settle[6:3] == 4'h0) else $error("settle reserved bits set"); // [RULE10]
    a_halt_gate: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        st_reg.standby[1:0] != 2'b00 |-> !O_CPU_CLK_EN) else $error("cpu clock in standby"); // [RULE23]
    a_halt_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        st_reg.standby[1:0] == 2'b01 && !I_INT_PENDING && !I_PROT_WR |=>
        st_reg.standby[0]) else $error("halt left without interrupt"); // [RULE24]
    a_halt_enter: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_PROT_WR && I_ADDR == 16'hffc0 && I_WDATA[1:0] == 2'b01 |=> ##1 !O_CPU_CLK_EN)
        else $error("halt not entered"); // [RULE18]
    a_standby_guard: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !I_PROT_WR && st_reg.standby[1:0] == 2'b00 |=> $stable(st_reg.standby[7:2]))
        else $error("standby changed by plain write"); // [RULE19]
    a_ext_osc: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_EXT_CLK_SEL |-> !O_MAIN_OSC_EN) else $error("osc runs with ext clock"); // [RULE14]
    a_ext_wait: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        s_stop_wake ##0 st_reg.settle[7] |=> ##1 (st_reg.wait_on && !O_CPU_CLK_EN)[*8])
        else $error("stop released before wait"); // [RULE25]
endmodule
`default_nettype wire

// File: tb_cso_clock_status.sv
// testbench: register access, standby modes and settle wait of the clock status block
`timescale 1ns/1ps
`default_nettype none
module tb_cso_clock_status
    import cso_pkg::*;
;
    logic clk = 1'b0;                 // 100 MHz system clock
    logic reset_n = 1'b0;             // held low for the first 10 cycles
    logic [15:0] addr = 16'h0000;     // register address
    logic wr = 1'b0;                  // byte write strobe
    logic bit_wr = 1'b0;              // single-bit write strobe
    logic [2:0] bit_sel = 3'h0;       // bit index for bit writes
    logic prot = 1'b0;                // protected standby write
    logic [7:0] wdata = 8'h00;        // write data
    logic rd_en = 1'b0;               // read strobe
    logic irq = 1'b0;                 // unmasked interrupt request
    logic [7:0] rdata;
    logic cpu_en, osc_en, ext_sel, sub_sel, sub_osc;
    logic [1:0] div_log;
    logic osc_mid;                    // oscillator enable seen during the settle wait
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    logic [7:0] modes [3] = '{8'h31, 8'h71, 8'h33}; // halt from main, halt from sub, idle

    always #5 clk = ~clk;

    cso_clock_status uut (.I_CLK(clk), .I_RESET_N(reset_n), .I_ADDR(addr), .I_WR(wr),
        .I_BIT_WR(bit_wr), .I_BIT_SEL(bit_sel), .I_PROT_WR(prot), .I_WDATA(wdata),
        .I_RD(rd_en), .I_INT_PENDING(irq), .O_RDATA(rdata), .O_CPU_CLK_EN(cpu_en),
        .O_MAIN_OSC_EN(osc_en), .O_EXT_CLK_SEL(ext_sel), .O_SUB_CLK_SEL(sub_sel),
        .O_CPU_DIV_LOG(div_log), .O_SUB_OSC_EN(sub_osc));

    ////////////////////////////////////////////////////////////////////////////////
    // compare tasks and the closing report
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks: strobes rise after one edge and drop after the edge that takes them
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic reg_read(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk8(what, exp, rdata);
    endtask
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bit_write(input logic [15:0] a, input logic [2:0] b, input logic v);
        @(posedge clk);
        addr <= a;
        bit_sel <= b;
        wdata <= {7'h00, v};
        bit_wr <= 1'b1;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask
    task automatic prot_write(input logic [7:0] d);
        @(posedge clk);
        addr <= CSO_ADDR_STANDBY;
        wdata <= d;
        prot <= 1'b1;
        @(posedge clk);
        prot <= 1'b0;
    endtask
    task automatic wake;
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
    endtask
    // stop, wake by interrupt, and time the wait until the cpu clock returns
    task automatic stop_run(input logic [7:0] s, input int limit);
        reg_write(CSO_ADDR_SETTLE, s);
        prot_write(8'h32);
        idle(2);
        chk1("cpu clock in stop", 1'b0, cpu_en);
        chk1("main osc in stop", 1'b0, osc_en);
        wake();
        n = 0;
        osc_mid = 1'bx;
        while (cpu_en !== 1'b1 && n < limit + 10) begin
            idle(1);
            n++;
            if (n == 4) osc_mid = osc_en;
        end
        chk1("settle wait length", 1'b1, n >= limit && n <= limit + 5);
        chk1("main osc during wait", ~s[CSO_EXT_CLOCK_SELECT_BIT], osc_mid);
        reg_read(CSO_ADDR_STANDBY, 8'h30, "standby after stop");
    endtask

    // hang guard: the whole run needs about 9000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("timeout after %0d cycles", cycles);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk8("reset outputs", 8'h67, {1'b0, cpu_en, osc_en, ext_sel, sub_sel, sub_osc, div_log});
        reg_read(CSO_ADDR_STATUS, 8'h32, "status after reset");
        reg_read(CSO_ADDR_SETTLE, 8'h00, "settle after reset");
        reg_read(16'hffd0, 8'h00, "unmapped read");
        $display("test reset done");
        reg_write(CSO_ADDR_SETTLE, 8'hff);
        reg_read(CSO_ADDR_SETTLE, 8'h87, "settle byte write");
        chk1("ext clock select", 1'b1, ext_sel);
        chk1("main osc with ext clock", 1'b0, osc_en);
        bit_write(CSO_ADDR_SETTLE, 3'h7, 1'b0);
        bit_write(CSO_ADDR_SETTLE, 3'h1, 1'b0);
        reg_read(CSO_ADDR_SETTLE, 8'h05, "settle bit writes");
        chk1("crystal select", 1'b0, ext_sel);
        $display("test settle register done");
        // plain writes must not reach status or standby
        reg_write(CSO_ADDR_STATUS, 8'h00);
        bit_write(CSO_ADDR_STATUS, 3'h1, 1'b0);
        reg_write(CSO_ADDR_STANDBY, 8'h31);
        reg_read(CSO_ADDR_STATUS, 8'h32, "status read only");
        chk1("cpu clock after plain write", 1'b1, cpu_en);
        for (n = 0; n < 4; n++) begin
            prot_write({2'b00, n[1:0], 4'h0});
            reg_read(CSO_ADDR_STATUS, {2'b00, n[1:0], 4'h2}, "status divider");
            chk8("divider output", {6'h00, n[1:0]}, {6'h00, div_log});
        end
        prot_write(8'hf4);
        reg_read(CSO_ADDR_STATUS, 8'hf7, "status mirror");
        chk1("sub clock select", 1'b1, sub_sel);
        chk1("sub osc enable", 1'b0, sub_osc);
        chk1("main osc stopped", 1'b0, osc_en);
        $display("test status mirror done");
        // halt from main clock, halt from subsystem clock, idle
        for (int i = 0; i < 3; i++) begin
            prot_write(8'h30);
            prot_write(modes[i]);
            idle(8);
            chk1("cpu clock held", 1'b0, cpu_en);
            reg_read(CSO_ADDR_STANDBY, modes[i], "standby in mode");
            wake();
            // three idle slots after release stand in for the software's no-ops
            idle(3);
            chk1("cpu clock resumed", 1'b1, cpu_en);
            reg_read(CSO_ADDR_STANDBY, modes[i] & 8'hfc, "request cleared");
        end
        prot_write(8'h30);
        $display("test halt and idle done");
        // ext clock chosen before stop, then crystal with the shortest wait twice
        stop_run(8'h80, 512);
        stop_run(8'h07, 4096);
        stop_run(8'h07, 4096);
        // short waits above only save run time; software leaves the longest wait set
        reg_write(CSO_ADDR_SETTLE, 8'h00);
        reg_read(CSO_ADDR_SETTLE, 8'h00, "settle longest wait");
        $display("test stop wait done");
        results();
    end
endmodule
`default_nettype wire
